/* bench/exec_reloc_assertions.sv */
`timescale 1ns/1ps
module exec_reloc_checker #(
    parameter PIF_WORDS = 64
) (
    input wire        clock_in,
    input wire        sys_rst_in,
    input wire        instr_valid_in,
    input wire [23:0] instr_word_in,
    input wire        regfile_write_in,
    input wire [5:0]  regfile_addr_in,
    input wire        enter_program_in,
    input wire        interrupt_in,
    input wire        suppress_out,
    input wire        index_op_noop_out,
    input wire        exec_intr_out,
    input wire        monitor_state_out,
    input wire        ref_valid_in,
    input wire [14:0] ref_addr_in,
    input wire        mem_valid_out,
    input wire [17:0] mem_addr_out,
    input wire        illegal_write_out
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (sys_rst_in);
    wire [11:0] op_hi = instr_word_in[23:12];
    wire        in_prog = instr_valid_in && !monitor_state_out;
    wire [8:0]  ref_low = ref_addr_in[8:0];
    property p_trap;
        suppress_out |=> exec_intr_out && monitor_state_out;
    endproperty
    a_trap: assert property (p_trap) else $error("no trap");
    property p_cause;
        exec_intr_out |-> $past(suppress_out);
    endproperty
    a_cause: assert property (p_cause) else $error("stray trap");
    property p_mon_free;
        monitor_state_out |-> !suppress_out;
    endproperty
    a_mon_free: assert property (p_mon_free) else $error("monitor");
    property p_enter;
        enter_program_in && !interrupt_in && !suppress_out
            |=> !monitor_state_out;
    endproperty
    a_enter: assert property (p_enter) else $error("no entry");
    property p_halt;
        in_prog && instr_word_in[23:15] == 9'h000 |-> suppress_out;
    endproperty
    a_halt: assert property (p_halt) else $error("halt ran");
    property p_range;
        in_prog && op_hi[11:9] == 3'h7 && op_hi[8:6] != 3'h0 &&
            op_hi != 12'hff9 && op_hi != 12'hffa |-> suppress_out;
    endproperty
    a_range: assert property (p_range) else $error("range ran");
    property p_regfile;
        regfile_write_in && !monitor_state_out && regfile_addr_in <= 6'h1f
            |-> suppress_out;
    endproperty
    a_regfile: assert property (p_regfile) else $error("regfile");
    property p_answer;
        ref_valid_in |=> mem_valid_out != illegal_write_out;
    endproperty
    a_answer: assert property (p_answer) else $error("answer");
    property p_offset;
        ref_valid_in |=> mem_addr_out[8:0] == $past(ref_low);
    endproperty
    a_offset: assert property (p_offset) else $error("offset");
    property p_noop;
        index_op_noop_out |-> instr_valid_in &&
            (op_hi == 12'hff4 || op_hi == 12'hff5);
    endproperty
    a_noop: assert property (p_noop) else $error("noop");
endmodule // exec_reloc_checker

bind executive_state_relocation_unit exec_reloc_checker #(
    .PIF_WORDS(PIF_WORDS)
) chk_u (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .instr_valid_in(instr_valid_in), .instr_word_in(instr_word_in),
    .regfile_write_in(regfile_write_in),
    .regfile_addr_in(regfile_addr_in),
    .enter_program_in(enter_program_in), .interrupt_in(interrupt_in),
    .suppress_out(suppress_out), .index_op_noop_out(index_op_noop_out),
    .exec_intr_out(exec_intr_out), .monitor_state_out(monitor_state_out),
    .ref_valid_in(ref_valid_in), .ref_addr_in(ref_addr_in),
    .mem_valid_out(mem_valid_out), .mem_addr_out(mem_addr_out),
    .illegal_write_out(illegal_write_out)
);

/* bench/seq_model.sv */
`timescale 1ns/1ps
// Released instruction words and reference addresses show inverted data so a stale request never passes.
module seq_model (
    input  wire        clock_in,
    output reg         instr_valid_out = 1'b0,
    output reg  [23:0] instr_word_out = 24'h0,
    output reg         regfile_write_out = 1'b0,
    output reg  [5:0]  regfile_addr_out = 6'h0,
    output reg         enter_program_out = 1'b0,
    output reg         interrupt_out = 1'b0,
    output reg         ref_valid_out = 1'b0,
    output reg         ref_operand_out = 1'b0,
    output reg         ref_write_out = 1'b0,
    output reg         ref_io_out = 1'b0,
    output reg  [14:0] ref_addr_out = 15'h0
);
    task instr(input [23:0] w, input rf);
        begin
            @(posedge clock_in);
            instr_valid_out <= !rf;
            regfile_write_out <= rf;
            instr_word_out <= w;
            regfile_addr_out <= w[5:0];
            @(negedge clock_in);
        end
    endtask
    task mref(input op, input wr, input io, input [14:0] a);
        begin
            @(posedge clock_in);
            ref_valid_out <= 1'b1;
            ref_operand_out <= op;
            ref_write_out <= wr;
            ref_io_out <= io;
            ref_addr_out <= a;
            @(negedge clock_in);
        end
    endtask
    task pulse(input en, input intr);
        begin
            @(posedge clock_in);
            enter_program_out <= en;
            interrupt_out <= intr;
            @(negedge clock_in);
        end
    endtask
    task idle;
        begin
            @(posedge clock_in);
            {instr_valid_out, regfile_write_out, ref_valid_out} <= 3'h0;
            {enter_program_out, interrupt_out} <= 2'h0;
            instr_word_out <= ~instr_word_out;
            ref_addr_out <= ~ref_addr_out;
            @(negedge clock_in);
        end
    endtask
endmodule // seq_model

/* bench/tb_executive_state_relocation_unit.sv */
`timescale 1ns/1ps
module tb_executive_state_relocation_unit;
    reg         clock_in = 1'b0;
    reg         sys_rst_in = 1'b1;
    reg         psel_in = 1'b0;
    reg         penable_in = 1'b0;
    reg         pwrite_in = 1'b0;
    reg  [7:0]  paddr_in = 8'h00;
    reg  [31:0] pwdata_in = 32'h0;
    wire [31:0] prdata_out;
    wire        pready_out, pslverr_out, instr_valid_in, regfile_write_in;
    wire        enter_program_in, interrupt_in, ref_valid_in, ref_io_in;
    wire        ref_operand_in, ref_write_in, suppress_out, exec_intr_out;
    wire        index_op_noop_out, monitor_state_out, mem_valid_out;
    wire        illegal_write_out;
    wire [23:0] instr_word_in;
    wire [5:0]  regfile_addr_in;
    wire [14:0] ref_addr_in;
    wire [17:0] mem_addr_out;
    integer     fail_count = 0;
    integer     num_checks = 0;
    integer     i;
    reg  [31:0] rd;
    reg         er;
    // Row: register-file flag, expected trap, instruction word.
    reg  [25:0] rows [0:11] = '{26'h1000000, 26'h0008000, 26'h0e00000,
        26'h1e40000, 26'h1f00000, 26'h1ff8000, 26'h0ff9000, 26'h0ffa000,
        26'h1ff4000, 26'h0b60000, 26'h300001f, 26'h2000020};

    always #4 clock_in = ~clock_in;

    executive_state_relocation_unit #(.PIF_WORDS(64)) dut_u (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in),
        .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .instr_valid_in(instr_valid_in),
        .instr_word_in(instr_word_in), .regfile_write_in(regfile_write_in),
        .regfile_addr_in(regfile_addr_in),
        .enter_program_in(enter_program_in), .interrupt_in(interrupt_in),
        .suppress_out(suppress_out), .index_op_noop_out(index_op_noop_out),
        .exec_intr_out(exec_intr_out),
        .monitor_state_out(monitor_state_out),
        .ref_valid_in(ref_valid_in), .ref_operand_in(ref_operand_in),
        .ref_write_in(ref_write_in), .ref_io_in(ref_io_in),
        .ref_addr_in(ref_addr_in), .mem_valid_out(mem_valid_out),
        .mem_addr_out(mem_addr_out), .illegal_write_out(illegal_write_out)
    );

    seq_model seq_u (
        .clock_in(clock_in), .instr_valid_out(instr_valid_in),
        .instr_word_out(instr_word_in),
        .regfile_write_out(regfile_write_in),
        .regfile_addr_out(regfile_addr_in),
        .enter_program_out(enter_program_in),
        .interrupt_out(interrupt_in), .ref_valid_out(ref_valid_in),
        .ref_operand_out(ref_operand_in), .ref_write_out(ref_write_in),
        .ref_io_out(ref_io_in), .ref_addr_out(ref_addr_in)
    );

    task chk32(input [31:0] g, input [31:0] e);
        begin
            num_checks = num_checks + 1;
            if (g !== e) begin
                fail_count = fail_count + 1;
                $display("Error %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask
    task chk1(input g, input e);
        begin
            num_checks = num_checks + 1;
            if (g !== e) begin
                fail_count = fail_count + 1;
                $display("Error %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask
    // The wait for pready has no limit of its own; the watchdog ends it.
    task apb(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge clock_in);
            psel_in <= 1'b1;
            penable_in <= 1'b0;
            pwrite_in <= w;
            paddr_in <= a;
            pwdata_in <= d;
            @(posedge clock_in);
            penable_in <= 1'b1;
            @(posedge clock_in);
            while (pready_out !== 1'b1) begin
                @(posedge clock_in);
            end
            rd = prdata_out;
            er = pslverr_out;
            psel_in <= 1'b0;
            penable_in <= 1'b0;
        end
    endtask
    task rchk(input op, input wr, input io, input [14:0] a, input ill,
              input [17:0] e);
        begin
            seq_u.mref(op, wr, io, a);
            seq_u.idle;
            chk1(illegal_write_out, ill);
            chk1(mem_valid_out, !ill);
            if (!ill)
                chk32({14'h0, mem_addr_out}, {14'h0, e});
        end
    endtask
    task stop_test;
        begin
            $display("Checks %0d, mismatches %0d", num_checks, fail_count);
            if (fail_count == 0 && num_checks > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask

    initial begin
        #40000;
        fail_count = fail_count + 1;
        stop_test;
    end

    initial begin
        repeat (6) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        @(negedge clock_in);
        chk1(monitor_state_out, 1'b1);
        apb(1'b0, 8'h04, 32'h0);
        chk32(rd, 32'h0);
        apb(1'b1, 8'h08, 32'h5);
        apb(1'b1, 8'h0c, 32'h3);
        apb(1'b0, 8'h08, 32'h0);
        chk32(rd, 32'h5);
        apb(1'b0, 8'h1c, 32'h0);
        chk1(er, 1'b1);
        rchk(1'b0, 1'b0, 1'b0, 15'h1234, 1'b0, 18'h01234);
        seq_u.instr(24'hb60000, 1'b0);
        seq_u.idle;
        rchk(1'b1, 1'b0, 1'b0, 15'h1234, 1'b0, 18'h19234);
        rchk(1'b0, 1'b0, 1'b0, 15'h1234, 1'b0, 18'h01234);
        seq_u.pulse(1'b1, 1'b0);
        seq_u.idle;
        rchk(1'b0, 1'b0, 1'b0, 15'h1234, 1'b0, 18'h09234);
        rchk(1'b1, 1'b0, 1'b0, 15'h1234, 1'b0, 18'h19234);
        seq_u.instr(24'hb40000, 1'b0);
        seq_u.idle;
        rchk(1'b1, 1'b0, 1'b0, 15'h1234, 1'b0, 18'h09234);
        apb(1'b1, 8'h08, 32'h2);
        chk1(er, 1'b1);
        apb(1'b0, 8'h08, 32'h0);
        chk32(rd, 32'h5);
        seq_u.pulse(1'b0, 1'b1);
        seq_u.idle;
        chk1(monitor_state_out, 1'b1);
        rchk(1'b1, 1'b0, 1'b0, 15'h1234, 1'b0, 18'h01234);
        for (i = 0; i < 12; i = i + 1) begin
            seq_u.pulse(1'b1, 1'b0);
            seq_u.idle;
            seq_u.instr(rows[i][23:0], rows[i][25]);
            chk1(suppress_out, rows[i][24]);
            seq_u.idle;
            chk1(exec_intr_out, rows[i][24]);
            chk1(monitor_state_out, rows[i][24]);
        end
        seq_u.pulse(1'b0, 1'b1);
        seq_u.idle;
        seq_u.instr(24'hff4000, 1'b0);
        chk1(index_op_noop_out, 1'b1);
        seq_u.idle;
        apb(1'b1, 8'h10, 32'h2b);
        apb(1'b1, 8'h14, 32'h357849);
        apb(1'b0, 8'h14, 32'h0);
        chk32(rd, 32'h0);
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b1, 8'h14, 32'h357849);
        apb(1'b0, 8'h14, 32'h0);
        chk32(rd, 32'h357849);
        seq_u.instr(24'hff5000, 1'b0);
        chk1(index_op_noop_out, 1'b0);
        seq_u.idle;
        seq_u.pulse(1'b1, 1'b0);
        seq_u.idle;
        rchk(1'b0, 1'b0, 1'b0, 15'h30a5, 1'b0, 18'h2aea5);
        rchk(1'b0, 1'b0, 1'b1, 15'h32a5, 1'b0, 18'h2a8a5);
        rchk(1'b0, 1'b0, 1'b0, 15'h32a5, 1'b1, 18'h0);
        rchk(1'b0, 1'b0, 1'b0, 15'h3ca5, 1'b0, 18'h096a5);
        rchk(1'b0, 1'b1, 1'b0, 15'h3ca5, 1'b1, 18'h0);
        rchk(1'b0, 1'b1, 1'b0, 15'h30a5, 1'b0, 18'h2aea5);
        apb(1'b0, 8'h04, 32'h0);
        chk32(rd, 32'hd);
        @(posedge clock_in);
        sys_rst_in <= 1'b1;
        @(posedge clock_in);
        sys_rst_in <= 1'b0;
        @(negedge clock_in);
        chk1(monitor_state_out, 1'b1);
        apb(1'b0, 8'h04, 32'h0);
        chk32(rd, 32'h0);
        stop_test;
    end
endmodule // tb_executive_state_relocation_unit

/* verilog/exec_reloc_defs.vh */
`ifndef EXEC_RELOC_DEFS_VH
`define EXEC_RELOC_DEFS_VH

// APB byte offsets.
`define OFS_CONTROL       8'h00
`define OFS_STATUS        8'h04
`define OFS_INSTR_GROUP   8'h08
`define OFS_OPND_GROUP    8'h0c
`define OFS_PIF_POINTER   8'h10
`define OFS_PIF_DATA      8'h14

// Control and status bit positions.
`define CTL_RELOC_BIT     0
`define STS_PROGRAM_BIT   0
`define STS_OPND_OSR_BIT  1
`define STS_TRAP_BIT      2
`define STS_ILLEGAL_BIT   3

// Reset values.
`define RST_CONTROL       1'b0
`define RST_GROUP         3'h0

// Instruction word fields.
`define FUNC_HI           23
`define FUNC_LO           18
`define SUB3_HI           17
`define SUB3_LO           15
`define SUB6_HI           17
`define SUB6_LO           12

// Function and sub codes, octal.
`define FUNC_HALT         6'o00
`define SUB_HALT          3'o0
`define FUNC_RELOC        6'o55
`define SUB_RELOC_OPND    3'o4
`define SUB_RELOC_INSTR   3'o0
`define FUNC_PRIV_LOW     6'o71
`define FUNC_PRIV_HIGH    6'o77
`define FUNC_SPECIAL      6'o77
`define SUB_EXEMPT_A      6'o71
`define SUB_EXEMPT_B      6'o72
`define SUB_LOAD_INDEX    6'o64
`define SUB_READ_INDEX    6'o65
`define REGFILE_PRIV_TOP  6'o37

// Page index fields within one 12-bit index.
`define PI_EXCL_BIT       11
`define PI_QCNT_HI        10
`define PI_QCNT_LO        9
`define PI_FRAME_HI       8
`define PI_FRAME_LO       2
`define PI_START_HI       1
`define PI_START_LO       0

`endif

/* verilog/executive_state_relocation_unit.v */
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "exec_reloc_defs.vh"

module executive_state_relocation_unit #(
    parameter PIF_WORDS = 64
) (
    input  wire        clock_in,
    input  wire        sys_rst_in,
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [7:0]  paddr_in,
    input  wire [31:0] pwdata_in,
    output wire [31:0] prdata_out,
    output wire        pready_out,
    output wire        pslverr_out,
    input  wire        instr_valid_in,
    input  wire [23:0] instr_word_in,
    input  wire        regfile_write_in,
    input  wire [5:0]  regfile_addr_in,
    input  wire        enter_program_in,
    input  wire        interrupt_in,
    output wire        suppress_out,
    output wire        index_op_noop_out,
    output reg         exec_intr_out,
    output wire        monitor_state_out,
    input  wire        ref_valid_in,
    input  wire        ref_operand_in,
    input  wire        ref_write_in,
    input  wire        ref_io_in,
    input  wire [14:0] ref_addr_in,
    output reg         mem_valid_out,
    output reg  [17:0] mem_addr_out,
    output reg         illegal_write_out
);
    localparam ST_MONITOR = 2'b01;
    localparam ST_PROGRAM = 2'b10;

    reg  [1:0]  state_ff;
    reg  [1:0]  nxt_state;
    reg         opnd_osr_ff;
    reg         nxt_opnd_osr;
    reg         reloc_en_ff;
    reg  [2:0]  instr_group_reg_ff;
    reg  [2:0]  operand_group_reg_ff;
    reg  [5:0]  pif_pointer_ff;
    reg         trap_seen_ff;
    reg         illegal_seen_ff;
    reg  [31:0] prdata_ff;
    reg  [31:0] rd_value;
    reg         addr_hit;

    wire        in_monitor;
    wire        priv_op;
    wire        reloc_opnd;
    wire        reloc_instr;
    wire        index_op;
    wire        priv_attempt;
    wire        enter_monitor;
    wire        setup;
    wire        access;
    wire        wr_access;
    wire        group_wr;
    wire        refuse_wr;
    wire [23:0] pif_xlat_word;
    wire [23:0] pif_sw_word;
    wire        pif_wr;

    wire [2:0]  instr_group;
    wire [2:0]  opnd_group;
    wire [2:0]  ref_group;
    wire [11:0] page_index;
    wire        excl_flag;
    wire [1:0]  quarter_count_field;
    wire [6:0]  physical_frame_field;
    wire [1:0]  start_quarter_field;
    wire [1:0]  phys_quarter;
    wire        read_only_hit;
    wire        excluded_hit;
    wire        quarter_over;
    wire        illegal_ref;
    wire [17:0] reloc_addr;
    wire [17:0] plain_addr;

    assign in_monitor        = state_ff[0];
    assign monitor_state_out = in_monitor;

    privilege_decode u_decode (
        .instr_word_in   (instr_word_in),
        .priv_op_out     (priv_op),
        .reloc_opnd_out  (reloc_opnd),
        .reloc_instr_out (reloc_instr),
        .index_op_out    (index_op)
    );

    // Every instruction is legal in monitor state.
    assign priv_attempt = !in_monitor && ((instr_valid_in && priv_op) ||
                          (regfile_write_in &&
                           (regfile_addr_in <= `REGFILE_PRIV_TOP)));

    // The trap has no enable term on purpose.
    assign suppress_out  = priv_attempt;
    assign enter_monitor = interrupt_in || priv_attempt;

    assign index_op_noop_out = instr_valid_in && index_op &&
                               !reloc_en_ff;

    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_MONITOR: begin
                if (!interrupt_in && enter_program_in) begin
                    nxt_state = ST_PROGRAM;
                end
            end
            ST_PROGRAM: begin
                if (enter_monitor) begin
                    nxt_state = ST_MONITOR;
                end
            end
            default: begin
                nxt_state = ST_MONITOR;
            end
        endcase
    end

    // Operand selection is untouched by the step into program state.
    always @* begin
        nxt_opnd_osr = opnd_osr_ff;
        if (enter_monitor) begin
            nxt_opnd_osr = 1'b0;
        end else if (instr_valid_in && reloc_opnd) begin
            nxt_opnd_osr = 1'b1;
        end else if (instr_valid_in && reloc_instr && !in_monitor) begin
            nxt_opnd_osr = 1'b0;
        end
    end

    always @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_ff      <= ST_MONITOR;
            opnd_osr_ff   <= 1'b0;
            exec_intr_out <= 1'b0;
        end else begin
            state_ff      <= nxt_state;
            opnd_osr_ff   <= nxt_opnd_osr;
            exec_intr_out <= priv_attempt;
        end
    end

    // Address selection.
    assign instr_group = in_monitor ? 3'h0 : instr_group_reg_ff;
    assign opnd_group  = opnd_osr_ff ? operand_group_reg_ff :
                                       instr_group;
    assign ref_group   = ref_operand_in ? opnd_group : instr_group;

    page_index_file #(
        .WORDS (PIF_WORDS),
        .AW    (6),
        .DW    (24)
    ) u_pif (
        .clock_in      (clock_in),
        .sys_rst_in    (sys_rst_in),
        .wr_en_in      (pif_wr),
        .wr_addr_in    (pif_pointer_ff),
        .wr_data_in    (pwdata_in[23:0]),
        .xlat_addr_in  ({ref_group, ref_addr_in[14:12]}),
        .xlat_data_out (pif_xlat_word),
        .sw_addr_in    (pif_pointer_ff),
        .sw_data_out   (pif_sw_word)
    );

    // The even index sits in the upper half of the word.
    assign page_index = ref_addr_in[11] ? pif_xlat_word[11:0] :
                                          pif_xlat_word[23:12];

    assign excl_flag            = page_index[`PI_EXCL_BIT];
    assign quarter_count_field  = page_index[`PI_QCNT_HI:`PI_QCNT_LO];
    assign physical_frame_field = page_index[`PI_FRAME_HI:`PI_FRAME_LO];
    assign start_quarter_field  = page_index[`PI_START_HI:`PI_START_LO];

    // Two-bit sum drops its carry so quarters wrap within the page.
    assign phys_quarter = start_quarter_field + ref_addr_in[10:9];

    assign reloc_addr = {physical_frame_field, phys_quarter,
                         ref_addr_in[8:0]};
    // Only two group bits fit below the 131072-word limit.
    assign plain_addr = {1'b0, ref_group[1:0], ref_addr_in};

    assign read_only_hit = excl_flag && ref_write_in &&
                           (page_index[10:0] != 11'h000);
    assign excluded_hit  = excl_flag &&
                           (page_index[10:0] == 11'h000);
    // A zero count means a full page of four quarters.
    assign quarter_over  = (quarter_count_field != 2'h0) &&
                           (ref_addr_in[10:9] >= quarter_count_field) &&
                           !in_monitor && !ref_io_in;
    assign illegal_ref   = reloc_en_ff &&
                           (read_only_hit || excluded_hit || quarter_over);

    always @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            mem_valid_out     <= 1'b0;
            mem_addr_out      <= 18'h00000;
            illegal_write_out <= 1'b0;
        end else begin
            mem_valid_out     <= ref_valid_in && !illegal_ref;
            illegal_write_out <= ref_valid_in && illegal_ref;
            if (ref_valid_in) begin
                mem_addr_out <= reloc_en_ff ? reloc_addr : plain_addr;
            end
        end
    end

    // APB slave, zero wait states, read data caught in setup.
    assign setup     = psel_in && !penable_in;
    assign access    = psel_in && penable_in;
    assign wr_access = access && pwrite_in;
    assign group_wr  = (paddr_in == `OFS_INSTR_GROUP) ||
                       (paddr_in == `OFS_OPND_GROUP);
    assign refuse_wr = wr_access && group_wr && !in_monitor;
    assign pif_wr    = wr_access && (paddr_in == `OFS_PIF_DATA) &&
                       reloc_en_ff;

    assign pready_out  = access;
    assign pslverr_out = access && (!addr_hit || refuse_wr);
    assign prdata_out  = prdata_ff;

    always @* begin
        rd_value = 32'h00000000;
        addr_hit = 1'b1;
        if (paddr_in == `OFS_CONTROL) begin
            rd_value[`CTL_RELOC_BIT] = reloc_en_ff;
        end else if (paddr_in == `OFS_STATUS) begin
            rd_value[`STS_PROGRAM_BIT]  = !in_monitor;
            rd_value[`STS_OPND_OSR_BIT] = opnd_osr_ff;
            rd_value[`STS_TRAP_BIT]     = trap_seen_ff;
            rd_value[`STS_ILLEGAL_BIT]  = illegal_seen_ff;
        end else if (paddr_in == `OFS_INSTR_GROUP) begin
            rd_value[2:0] = instr_group_reg_ff;
        end else if (paddr_in == `OFS_OPND_GROUP) begin
            rd_value[2:0] = operand_group_reg_ff;
        end else if (paddr_in == `OFS_PIF_POINTER) begin
            rd_value[5:0] = pif_pointer_ff;
        end else if (paddr_in == `OFS_PIF_DATA) begin
            if (reloc_en_ff) begin
                rd_value[23:0] = pif_sw_word;
            end
        end else begin
            addr_hit = 1'b0;
        end
    end

    always @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            prdata_ff            <= 32'h00000000;
            reloc_en_ff          <= `RST_CONTROL;
            instr_group_reg_ff   <= `RST_GROUP;
            operand_group_reg_ff <= `RST_GROUP;
            pif_pointer_ff       <= 6'h00;
            trap_seen_ff         <= 1'b0;
            illegal_seen_ff      <= 1'b0;
        end else begin
            if (setup && !pwrite_in) begin
                prdata_ff <= rd_value;
            end
            if (wr_access && (paddr_in == `OFS_CONTROL)) begin
                reloc_en_ff <= pwdata_in[`CTL_RELOC_BIT];
            end
            if (wr_access && (paddr_in == `OFS_INSTR_GROUP) && in_monitor) begin
                instr_group_reg_ff <= pwdata_in[2:0];
            end
            if (wr_access && (paddr_in == `OFS_OPND_GROUP) && in_monitor) begin
                operand_group_reg_ff <= pwdata_in[2:0];
            end
            if (wr_access && (paddr_in == `OFS_PIF_POINTER)) begin
                pif_pointer_ff <= pwdata_in[5:0];
            end
            // A new event wins over a clear in the same cycle.
            if (priv_attempt) begin
                trap_seen_ff <= 1'b1;
            end else if (wr_access && (paddr_in == `OFS_STATUS) &&
                         pwdata_in[`STS_TRAP_BIT]) begin
                trap_seen_ff <= 1'b0;
            end
            if (ref_valid_in && illegal_ref) begin
                illegal_seen_ff <= 1'b1;
            end else if (wr_access && (paddr_in == `OFS_STATUS) &&
                         pwdata_in[`STS_ILLEGAL_BIT]) begin
                illegal_seen_ff <= 1'b0;
            end
        end
    end
endmodule // executive_state_relocation_unit

/* verilog/page_index_file.v */
`timescale 1ns/1ps

module page_index_file #(
    parameter WORDS = 64,
    parameter AW    = 6,
    parameter DW    = 24
) (
    input  wire          clock_in,
    input  wire          sys_rst_in,
    input  wire          wr_en_in,
    input  wire [AW-1:0] wr_addr_in,
    input  wire [DW-1:0] wr_data_in,
    input  wire [AW-1:0] xlat_addr_in,
    output wire [DW-1:0] xlat_data_out,
    input  wire [AW-1:0] sw_addr_in,
    output wire [DW-1:0] sw_data_out
);
    reg [DW-1:0] word_ff [0:WORDS-1];

    genvar i;
    generate
        for (i = 0; i < WORDS; i = i + 1) begin : g_word
            localparam [AW-1:0] IDX = i;
            always @(posedge clock_in or posedge sys_rst_in) begin
                if (sys_rst_in) begin
                    word_ff[i] <= {DW{1'b0}};
                end else if (wr_en_in && (wr_addr_in == IDX)) begin
                    word_ff[i] <= wr_data_in;
                end
            end
        end
    endgenerate

    assign xlat_data_out = word_ff[xlat_addr_in];
    assign sw_data_out   = word_ff[sw_addr_in];
endmodule // page_index_file

/* verilog/privilege_decode.v */
`timescale 1ns/1ps
`include "exec_reloc_defs.vh"

module privilege_decode (
    input  wire [23:0] instr_word_in,
    output wire        priv_op_out,
    output wire        reloc_opnd_out,
    output wire        reloc_instr_out,
    output wire        index_op_out
);
    wire [5:0] func;
    wire [2:0] sub3;
    wire [5:0] sub6;
    wire       halt_op;
    wire       high_op;
    wire       exempt_op_a;
    wire       exempt_op_b;

    assign func = instr_word_in[`FUNC_HI:`FUNC_LO];
    assign sub3 = instr_word_in[`SUB3_HI:`SUB3_LO];
    assign sub6 = instr_word_in[`SUB6_HI:`SUB6_LO];

    assign halt_op = (func == `FUNC_HALT) && (sub3 == `SUB_HALT);
    // The unconditional-stop op (func 00) sits outside this range and is caught by halt_op.
    assign high_op = (func >= `FUNC_PRIV_LOW) && (func <= `FUNC_PRIV_HIGH);
    assign exempt_op_a = (func == `FUNC_SPECIAL) && (sub6 == `SUB_EXEMPT_A);
    assign exempt_op_b = (func == `FUNC_SPECIAL) && (sub6 == `SUB_EXEMPT_B);

    assign priv_op_out = halt_op ||
                         (high_op && !exempt_op_a && !exempt_op_b);

    assign reloc_opnd_out  = (func == `FUNC_RELOC) &&
                             (sub3 == `SUB_RELOC_OPND);
    assign reloc_instr_out = (func == `FUNC_RELOC) &&
                             (sub3 == `SUB_RELOC_INSTR);
    assign index_op_out    = (func == `FUNC_SPECIAL) &&
                             ((sub6 == `SUB_LOAD_INDEX) ||
                              (sub6 == `SUB_READ_INDEX));
endmodule // privilege_decode
